// ==== fsca_consts.svh ====
// Summary of operation
// - Control failsafe asserts after a configurable interval without control-terminal messages, except while in override.
// - Control failsafe clears at once on a valid message or override entry.
// - Six telemetry outputs, each counting three hours after losing one of four channels.
// - Entering override restarts every failsafe timer from its full value.
// - The mute status channel going off ends active telemetry failsafe.
// - Control is released after four seconds on status or command, twenty on telemetry.
// - Raise or lower presses while holding control restart the session timeout.
// - A second take-control press while holding control releases it.
// - One owner at a time; panel waits for others, others wait for panel.
// - Override denies control to every control-terminal requester.
// - With several control terminals, only the current master may take control.
// - Lockout toggles terminal-device control permission and never times out.
// - Sites run 0 to 64; site zero requests no data, polling continues.
// - Display marks: uninstalled, stale, alarmed and muted indications.
// - An operation needing file memory while memory is full shows file-full.
// - Power-up switch codes 099 wipe, 199 grow; normal needs hundreds at 1.
// - Uninitialised memory prompts; initialise only after yes; pu_state stays in FSCA_PU_PROMPT until then, other logic runs.
// - Leaving override also restarts timers; override state is held externally nonvolatile.
`ifndef FSCA_CONSTS_SVH
`define FSCA_CONSTS_SVH
`define FSCA_CLK_HZ 10_000_000
`define FSCA_TICK_MS 100
`define FSCA_TELEM_HOURS 3
`define FSCA_CTRL_TO_TLM_S 20
`define FSCA_CTRL_TO_STS_S 4
`define FSCA_SITE_MAX 7'h40
`define FSCA_CODE_WIPE 12'h099
`define FSCA_CODE_GROW 12'h199
`define FSCA_HUND_NORMAL 4'h1
`define FSCA_PFX_BLANK 8'h20
`define FSCA_PFX_QUERY 8'h3F
`define FSCA_PFX_ALARM 8'h2A
`define FSCA_PFX_MUTE 8'h5B
`endif

// ==== fsca_pkg.sv ====
package fsca_pkg;
   typedef enum logic [1:0] {FSCA_OWN_NONE, FSCA_OWN_PANEL, FSCA_OWN_TERM} fsca_owner_t;
   typedef enum logic [2:0] {FSCA_PU_READ, FSCA_PU_WIPE, FSCA_PU_GROW, FSCA_PU_PROMPT,
                             FSCA_PU_RUN, FSCA_PU_HALT} fsca_pu_t;
   typedef struct packed {
      logic uninstalled;
      logic stale;
      logic alarmed;
      logic muted;
   } fsca_disp_t;
endpackage : fsca_pkg

// ==== fsca_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fsca_consts.svh"
module fsca_top
   import fsca_pkg::*;
#(
   parameter int TICK_CYCLES = (`FSCA_CLK_HZ / 1000) * `FSCA_TICK_MS,
   parameter int TELEM_TICKS = `FSCA_TELEM_HOURS * 3600 * (1000 / `FSCA_TICK_MS),
   parameter int N_OUT = 6,
   parameter int N_MON = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] ctrl_wait_ticks,
   input wire logic valid_msg,
   input wire logic override_key,
   input wire logic [N_OUT*N_MON-1:0] telem_lost,
   input wire logic mute_status,
   input wire logic take_panel,
   input wire logic take_term,
   input wire logic raise_lower,
   input wire logic show_telem,
   input wire logic is_master,
   input wire logic lockout_toggle,
   input wire logic [6:0] site_sel,
   input wire logic [11:0] switch_code,
   input wire logic init_yes,
   input wire logic file_free,
   input wire logic op_needs_mem,
   input wire logic mem_done,
   input wire logic mem_valid,
   input wire fsca_disp_t disp_in,
   output logic ctrl_failsafe,
   output logic [N_OUT-1:0] telem_failsafe,
   output logic local_override,
   output fsca_owner_t owner,
   output logic term_locked,
   output logic site_request,
   output logic [6:0] site_reg,
   output fsca_pu_t pu_state,
   output logic wipe_go,
   output logic grow_go,
   output logic report_done,
   output logic file_full,
   output fsca_disp_t disp_out,
   output logic [7:0] disp_prefix
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int LW = $clog2(TELEM_TICKS + 1);
   localparam int TPS = 1000 / `FSCA_TICK_MS;
   localparam logic [7:0] SESS_TLM = 8'(`FSCA_CTRL_TO_TLM_S * TPS);
   localparam logic [7:0] SESS_STS = 8'(`FSCA_CTRL_TO_STS_S * TPS);

   // ---------------------------------------------------------------
   // Common tick
   // ---------------------------------------------------------------
   logic [TW-1:0] div_reg;
   logic tick;
   always_ff @(posedge clk) begin
      if (!nrst || div_reg == TW'(TICK_CYCLES - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + TW'(1);
      end
   end
   assign tick = (div_reg == TW'(TICK_CYCLES - 1));

   // ---------------------------------------------------------------
   // Override toggle
   // ---------------------------------------------------------------
   logic ovr_chg;
   assign ovr_chg = override_key;
   // The stored copy lives in nonvolatile memory outside; reset here only clears it.
   // override state toggle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         local_override <= 1'b0;
      end else if (override_key) begin
         local_override <= !local_override;
      end
   end

   // ---------------------------------------------------------------
   // Control failsafe
   // ---------------------------------------------------------------
   logic [15:0] cwait_reg;
   // count quiet ticks, override restarts it
   always_ff @(posedge clk) begin
      if (!nrst || valid_msg || ovr_chg) begin
         cwait_reg <= '0;
      end else if (tick && cwait_reg != ctrl_wait_ticks) begin
         cwait_reg <= cwait_reg + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst || valid_msg || (override_key && !local_override)) begin
         ctrl_failsafe <= 1'b0;
      end else if (!local_override && tick && cwait_reg + 16'h0001 >= ctrl_wait_ticks) begin
         ctrl_failsafe <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Telemetry failsafe channels
   // ---------------------------------------------------------------
   logic mute_q;
   logic mute_off;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mute_q <= 1'b0;
      end else begin
         mute_q <= mute_status;
      end
   end
   assign mute_off = mute_q && !mute_status;

   genvar g;
   generate
      for (g = 0; g < N_OUT; g++) begin : g_tlm
         logic [LW-1:0] cnt_reg;
         logic lost;
         assign lost = |telem_lost[g*N_MON +: N_MON];
         always_ff @(posedge clk) begin
            if (!nrst || !lost || ovr_chg) begin
               cnt_reg <= '0;
            end else if (tick && cnt_reg != LW'(TELEM_TICKS)) begin
               cnt_reg <= cnt_reg + LW'(1);
            end
         end
         always_ff @(posedge clk) begin
            if (!nrst || !lost || ovr_chg || mute_off) begin
               telem_failsafe[g] <= 1'b0;
            end else if (tick && cnt_reg == LW'(TELEM_TICKS - 1)) begin
               telem_failsafe[g] <= 1'b1;
            end
         end
         property p_tlm_ovr;
            @(posedge clk) disable iff (!nrst) ovr_chg |=> cnt_reg == '0 && !telem_failsafe[g];
         endproperty
         a_tlm_ovr : assert property (p_tlm_ovr) else $error("override kept timer");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Control session arbitration
   // ---------------------------------------------------------------
   logic [7:0] sess_reg;
   logic sess_full;
   logic can_take;
   assign sess_full = (sess_reg == '0);
   // override and master gate all requests
   assign can_take = !local_override && is_master;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         term_locked <= 1'b0;
      end else if (lockout_toggle) begin
         term_locked <= !term_locked;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         owner <= FSCA_OWN_NONE;
      end else begin
         case (owner)
            FSCA_OWN_NONE: begin
               if (take_panel && can_take) begin
                  owner <= FSCA_OWN_PANEL;
               end else if (take_term && can_take && !term_locked) begin
                  owner <= FSCA_OWN_TERM;
               end
            end
            FSCA_OWN_PANEL: begin
               if (take_panel || !can_take || (tick && sess_reg == 8'h01)) begin
                  owner <= FSCA_OWN_NONE;
               end
            end
            FSCA_OWN_TERM: begin
               if (take_term || !can_take || term_locked || (tick && sess_reg == 8'h01)) begin
                  owner <= FSCA_OWN_NONE;
               end
            end
            default: owner <= FSCA_OWN_NONE;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst || owner == FSCA_OWN_NONE) begin
         sess_reg <= show_telem ? SESS_TLM : SESS_STS;
      end else if (raise_lower) begin
         sess_reg <= show_telem ? SESS_TLM : SESS_STS;
      end else if (tick && !sess_full) begin
         sess_reg <= sess_reg - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Site selection, power-up, file memory
   // ---------------------------------------------------------------
   // site range and zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         site_reg <= '0;
      end else if (site_sel <= `FSCA_SITE_MAX) begin
         site_reg <= site_sel;
      end
   end
   assign site_request = (site_reg != '0);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pu_state <= FSCA_PU_READ;
      end else begin
         case (pu_state)
            FSCA_PU_READ: begin
               if (switch_code == `FSCA_CODE_WIPE) begin
                  pu_state <= FSCA_PU_WIPE;
               end else if (switch_code == `FSCA_CODE_GROW) begin
                  pu_state <= FSCA_PU_GROW;
               end else if (switch_code[11:8] != `FSCA_HUND_NORMAL) begin
                  pu_state <= FSCA_PU_HALT;
               end else if (!mem_valid) begin
                  pu_state <= FSCA_PU_PROMPT;
               end else begin
                  pu_state <= FSCA_PU_RUN;
               end
            end
            FSCA_PU_WIPE, FSCA_PU_GROW: begin
               if (mem_done) begin
                  pu_state <= FSCA_PU_HALT;
               end
            end
            FSCA_PU_PROMPT: begin
               if (init_yes) begin
                  pu_state <= FSCA_PU_WIPE;
               end
            end
            FSCA_PU_RUN, FSCA_PU_HALT: pu_state <= pu_state;
            default: pu_state <= FSCA_PU_READ;
         endcase
      end
   end
   assign wipe_go = (pu_state == FSCA_PU_WIPE);
   assign grow_go = (pu_state == FSCA_PU_GROW);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         report_done <= 1'b0;
      end else if ((wipe_go || grow_go) && mem_done) begin
         report_done <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         file_full <= 1'b0;
      end else if (op_needs_mem) begin
         file_full <= !file_free;
      end
   end

   // ---------------------------------------------------------------
   // Display marks
   // ---------------------------------------------------------------
   // display prefix marks
   always_ff @(posedge clk) begin
      if (!nrst) begin
         disp_out <= '0;
         disp_prefix <= `FSCA_PFX_BLANK;
      end else begin
         disp_out <= disp_in;
         if (disp_in.uninstalled || disp_in.stale) begin
            disp_prefix <= `FSCA_PFX_QUERY;
         end else if (disp_in.alarmed) begin
            disp_prefix <= `FSCA_PFX_ALARM;
         end else if (disp_in.muted) begin
            disp_prefix <= `FSCA_PFX_MUTE;
         end else begin
            disp_prefix <= `FSCA_PFX_BLANK;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_msg_clr;
      @(posedge clk) disable iff (!nrst) valid_msg |=> !ctrl_failsafe;
   endproperty
   a_msg_clr : assert property (p_msg_clr) else $error("failsafe held after message");
   property p_fs_quiet;
      @(posedge clk) disable iff (!nrst) $rose(ctrl_failsafe) |-> !local_override;
   endproperty
   a_fs_quiet : assert property (p_fs_quiet) else $error("failsafe rose in override");
   property p_ovr_deny;
      @(posedge clk) disable iff (!nrst) local_override |=> owner == FSCA_OWN_NONE;
   endproperty
   a_ovr_deny : assert property (p_ovr_deny) else $error("control held in override");
   property p_second;
      @(posedge clk) disable iff (!nrst)
         owner == FSCA_OWN_PANEL && take_panel |=> owner == FSCA_OWN_NONE;
   endproperty
   a_second : assert property (p_second) else $error("second press kept control");
   property p_master;
      @(posedge clk) disable iff (!nrst)
         $past(owner) == FSCA_OWN_NONE && owner != FSCA_OWN_NONE |-> $past(is_master);
   endproperty
   a_master : assert property (p_master) else $error("non master took control");
   property p_lock;
      @(posedge clk) disable iff (!nrst)
         term_locked && owner == FSCA_OWN_NONE |=> owner != FSCA_OWN_TERM;
   endproperty
   a_lock : assert property (p_lock) else $error("locked terminal took control");
   property p_restart;
      @(posedge clk) disable iff (!nrst) owner != FSCA_OWN_NONE && raise_lower
         |=> sess_reg == ($past(show_telem) ? SESS_TLM : SESS_STS);
   endproperty
   a_restart : assert property (p_restart) else $error("session not restarted");
   property p_site0;
      @(posedge clk) disable iff (!nrst) site_sel == '0 |=> !site_request;
   endproperty
   a_site0 : assert property (p_site0) else $error("site zero requested data");
   property p_mute;
      @(posedge clk) disable iff (!nrst) mute_off |=> telem_failsafe == '0;
   endproperty
   a_mute : assert property (p_mute) else $error("mute off kept failsafe");
endmodule : fsca_top
`default_nettype wire

// ==== fsca_ct_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Control terminal link model
// ----
// Sends a valid message every PERIOD cycles while talk is high. Silence is
// how a lost link looks from the remote side, so talk low stops all traffic.
module fsca_ct_model #(
   parameter int PERIOD = 7
) (
   input wire logic clk,
   input wire logic talk,
   output logic valid_msg
);
   int cnt = 0;
   initial valid_msg = 1'b0;
   always @(negedge clk) begin
      cnt = (cnt + 1) % PERIOD;
      valid_msg = talk && (cnt == 0);
   end
endmodule : fsca_ct_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
   checked++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, g); \
   end \
end
module tb_top
   import fsca_pkg::*;
;
   // ----
   // Stimulus and helpers
   // ----
   logic clk = 0, nrst = 0, talk = 1, mute = 0, show_telem = 0, is_master = 1;
   logic file_free = 1, mem_valid = 1, vm, cf, lo, tlk, sreq, wg, gg, rd, ff;
   logic [7:0] p = 8'h00;
   logic [15:0] cw = 16'h0003;
   logic [23:0] tl = 24'h00_0000;
   logic [6:0] site = 7'h00;
   logic [11:0] sw = 12'h101;
   fsca_disp_t di = 4'h0;
   fsca_disp_t dout;
   logic [5:0] tf;
   logic [6:0] sreg;
   logic [7:0] pre;
   fsca_owner_t own;
   fsca_pu_t pu;
   int errors = 0, checked = 0;
   fsca_ct_model ct (.clk(clk), .talk(talk), .valid_msg(vm));
   fsca_top #(.TICK_CYCLES(10), .TELEM_TICKS(5)) uut (.clk(clk), .nrst(nrst),
      .ctrl_wait_ticks(cw), .valid_msg(vm), .override_key(p[0]), .telem_lost(tl),
      .mute_status(mute), .take_panel(p[1]), .take_term(p[2]), .raise_lower(p[3]),
      .show_telem(show_telem), .is_master(is_master), .lockout_toggle(p[4]),
      .site_sel(site), .switch_code(sw), .init_yes(p[7]), .file_free(file_free),
      .op_needs_mem(p[5]), .mem_done(p[6]), .mem_valid(mem_valid), .disp_in(di),
      .ctrl_failsafe(cf), .telem_failsafe(tf), .local_override(lo), .owner(own),
      .term_locked(tlk), .site_request(sreq), .site_reg(sreg), .pu_state(pu),
      .wipe_go(wg), .grow_go(gg), .report_done(rd), .file_full(ff), .disp_out(dout),
      .disp_prefix(pre));
   initial forever #50 clk = ~clk;
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   task automatic pulse(input int i);
      @(negedge clk) p[i] = 1'b1;
      @(negedge clk) p[i] = 1'b0;
   endtask : pulse
   task automatic boot(input logic [11:0] code);
      sw = code;
      nrst = 1'b0;
      wt(6);
      nrst = 1'b1;
      wt(4);
   endtask : boot
   task automatic conclude();
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // ----
   // Scenarios
   // ----
   task automatic t_boot();
      boot(12'h099);
      `CHK("wipe_go", 1'b1, wg)
      pulse(6);
      `CHK("report_done", 1'b1, rd)
      boot(12'h199);
      `CHK("grow_go", 1'b1, gg)
      boot(12'h205);
      `CHK("pu_state", FSCA_PU_HALT, pu)
      mem_valid = 1'b0;
      boot(12'h101);
      `CHK("pu_state", FSCA_PU_PROMPT, pu)
      pulse(7);
      `CHK("wipe_go", 1'b1, wg)
      mem_valid = 1'b1;
      boot(12'h101);
      `CHK("pu_state", FSCA_PU_RUN, pu)
      `CHK("disp_prefix", 8'h20, pre)
   endtask : t_boot
   task automatic t_ctrl();
      talk = 1'b0;
      wt(12);
      `CHK("ctrl_failsafe", 1'b0, cf)
      wt(28);
      `CHK("ctrl_failsafe", 1'b1, cf)
      talk = 1'b1;
      wt(9);
      `CHK("ctrl_failsafe", 1'b0, cf)
      talk = 1'b0;
      wt(40);
      pulse(0);
      `CHK("local_override", 1'b1, lo)
      `CHK("ctrl_failsafe", 1'b0, cf)
      pulse(1);
      pulse(2);
      `CHK("owner", FSCA_OWN_NONE, own)
      pulse(0);
      wt(16);
      `CHK("ctrl_failsafe", 1'b0, cf)
      wt(24);
      `CHK("ctrl_failsafe", 1'b1, cf)
      talk = 1'b1;
      wt(9);
   endtask : t_ctrl
   task automatic t_telem();
      mute = 1'b1;
      tl = 24'h00_0020;
      for (int r = 0; r < 2; r++) begin
         wt(38);
         `CHK("telem_failsafe", 6'h00, tf)
         wt(17);
         `CHK("telem_failsafe", 6'h02, tf)
         if (r == 0) begin
            pulse(0);
            `CHK("telem_failsafe", 6'h00, tf)
            pulse(0);
         end
      end
      mute = 1'b0;
      wt(2);
      `CHK("telem_failsafe", 6'h00, tf)
      tl = 24'h00_0000;
   endtask : t_telem
   task automatic t_sess();
      for (int s = 0; s < 2; s++) begin
         show_telem = s[0];
         pulse(1);
         wt(s ? 1900 : 380);
         `CHK("owner", FSCA_OWN_PANEL, own)
         wt(s ? 120 : 40);
         `CHK("owner", FSCA_OWN_NONE, own)
      end
      show_telem = 1'b0;
      pulse(1);
      wt(300);
      pulse(3);
      wt(300);
      `CHK("owner", FSCA_OWN_PANEL, own)
      pulse(1);
      `CHK("owner", FSCA_OWN_NONE, own)
      pulse(2);
      pulse(1);
      `CHK("owner", FSCA_OWN_TERM, own)
      pulse(2);
      pulse(1);
      pulse(2);
      `CHK("owner", FSCA_OWN_PANEL, own)
      pulse(1);
      pulse(4);
      pulse(2);
      `CHK("owner", FSCA_OWN_NONE, own)
      wt(450);
      `CHK("term_locked", 1'b1, tlk)
      pulse(4);
      `CHK("term_locked", 1'b0, tlk)
      is_master = 1'b0;
      pulse(2);
      `CHK("owner", FSCA_OWN_NONE, own)
      is_master = 1'b1;
   endtask : t_sess
   task automatic t_misc();
      logic [7:0] exp [4] = '{8'h3F, 8'h3F, 8'h2A, 8'h5B};
      site = 7'h40;
      wt(2);
      `CHK("site_reg", 7'h40, sreg)
      `CHK("site_request", 1'b1, sreq)
      site = 7'h41;
      wt(2);
      `CHK("site_reg", 7'h40, sreg)
      site = 7'h00;
      wt(2);
      `CHK("site_request", 1'b0, sreq)
      for (int i = 0; i < 4; i++) begin
         di = 4'h8 >> i;
         wt(2);
         `CHK("disp_prefix", exp[i], pre)
         `CHK("disp_out", di, dout)
      end
      pulse(5);
      `CHK("file_full", 1'b0, ff)
      file_free = 1'b0;
      pulse(5);
      `CHK("file_full", 1'b1, ff)
   endtask : t_misc
   initial begin
      #1_000_000;
      errors++;
      conclude();
   end
   initial begin
      t_boot();
      t_ctrl();
      t_telem();
      t_sess();
      t_misc();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
